/* pkg/cawd_pkg.sv */
package cawd_pkg;

	// register addresses on the special-function bus
	localparam logic [7:0] ADDR_CTL_STATUS = 8'hd8;
	localparam logic [7:0] ADDR_MODE = 8'hd9;
	localparam logic [7:0] ADDR_CNT_LOW = 8'he9;
	localparam logic [7:0] ADDR_CNT_HIGH = 8'hf9;
	localparam logic [7:0] ADDR_WD_OFFSET = 8'hee;
	localparam logic [7:0] ADDR_WD_UPDATE = 8'hfe;

	// control/status field positions
	localparam int CTL_OVF_BIT = 7;
	localparam int CTL_RUN_BIT = 6;
	localparam int CTL_UNUSED_BIT = 5;
	localparam int CTL_MOD4_BIT = 4;
	localparam int NUM_MODULES = 5;

	// mode register field positions
	localparam int MODE_IDLE_BIT = 7;
	localparam int MODE_WDTEN_BIT = 6;
	localparam int MODE_LOCK_BIT = 5;
	localparam int MODE_TB_LSB = 1;
	localparam int MODE_TB_MSB = 3;
	localparam int MODE_OVFIE_BIT = 0;

	// reset values
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] CNT_BYTE_RESET = 8'h00;
	localparam logic [7:0] WD_OFFSET_RESET = 8'h00;
	localparam logic [7:0] WD_UPDATE_RESET = 8'h00;
	localparam logic WDTEN_RESET = 1'b1;

	// counter timebase selections
	typedef enum logic [2:0] {
		CAWD_TB_DIV12 = 3'h0,
		CAWD_TB_DIV4 = 3'h1,
		CAWD_TB_TIMER0 = 3'h2,
		CAWD_TB_ECI = 3'h3,
		CAWD_TB_SYSTEM_CLOCK = 3'h4,
		CAWD_TB_EXTDIV8 = 3'h5
	} cawd_tb_t;
	localparam logic [2:0] TB_RESET = 3'h0;

	// prescaler ratios
	localparam logic [3:0] DIV12_LAST = 4'hb;
	localparam logic [3:0] DIV4_LAST = 4'h3;
	localparam logic [2:0] EXTDIV_LAST = 3'h7;

	localparam logic [7:0] BYTE_MAX = 8'hff;

endpackage

/* src/cawd_sync.sv */
`timescale 1ns/100ps
module cawd_sync
	import cawd_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input wire logic clk, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic [WIDTH-1:0] async_in, // pin level from outside the domain
	output logic [WIDTH-1:0] sync_out // level safe to use on clk
);

	logic [WIDTH-1:0] meta_q;

	// the first stage feeds only the second
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

/* src/cawd_top.sv */
`timescale 1ns/100ps
// Behaviour
// - Idle-suspend set halts counting during processor idle; clear keeps counting.
// - Timebase select and idle-suspend writes are ignored while the watchdog runs.
// - Setting either the enable bit or the lock bit enables the watchdog.
// - Once locked, the watchdog stays enabled until the next system reset.
// - Unlocked, clearing the enable bit disables the watchdog.
// - Reset gives watchdog on, divide-by-12 timebase, counter low and offset zero.
// - Reset defaults time out after 256 counter clocks, 3072 system clocks.
// - Counter wrap from all ones to zero sets the overflow flag, bit 7.
// - Enabled overflow flag raises the interrupt; only software clears the flag.
// - Control bit 6 is counter run: 1 counts; 0 stops only while the watchdog is off.
// - Control bit 5 reads zero and ignores writes.
// - Bits 4..0 are per-module event flags, set by hardware, cleared by software.
// - Control register at address 0xd8, all pages, supports single-bit set/clear.
// - Enabled watchdog resets when low byte overflows with high byte equal update byte.
// - Writing the update byte loads counter high byte plus offset instead.
// - Writing 1 to the module 4 flag while enabled forces an immediate reset.
// - Timebase codes: 000 divide-by-12, 001 divide-by-4, 100 undivided clock.
module cawd_top
	import cawd_pkg::*;
(
	input wire logic clk, // system clock, 100 MHz
	input wire logic resetn, // async reset, active low
	input wire logic [7:0] sfr_addr, // register address
	input wire logic sfr_wr, // byte write strobe
	input wire logic [7:0] sfr_wdata, // byte write data
	input wire logic sfr_bit_wr, // single-bit write strobe
	input wire logic [2:0] sfr_bit_idx, // bit index of a single-bit write
	input wire logic sfr_bit_val, // value of a single-bit write
	input wire logic sfr_rd, // read strobe
	output logic [7:0] sfr_rdata, // read data, one cycle after sfr_rd
	input wire logic cpu_idle, // processor idle level
	input wire logic timer0_ovf, // timer 0 overflow pulse, same clock
	input wire logic eci_pin, // external count input pin
	input wire logic ext_clk_pin, // external clock pin
	input wire logic [NUM_MODULES-1:0] module_event, // match/capture pulses per module
	input wire logic [NUM_MODULES-1:0] module_irq_en, // per-module interrupt enables
	output logic counter_irq, // counter array interrupt request
	output logic wd_reset_req // one-cycle watchdog reset request
);

	// register state
	logic ovf_flag_q;
	logic run_bit_q;
	logic [NUM_MODULES-1:0] event_flag_q;
	logic idle_suspend_q;
	logic wd_enable_q;
	logic wd_lock_q;
	logic [2:0] timebase_q;
	logic ovf_irq_en_q;
	logic [7:0] cnt_low_q;
	logic [7:0] cnt_high_q;
	logic [7:0] wd_offset_q;
	logic [7:0] wd_update_q;
	logic [3:0] presc_q;
	logic [2:0] ext_div_q;
	logic eci_prev_q;
	logic ext_prev_q;
	logic [7:0] rdata_q;
	logic irq_q;
	logic wd_req_q;

	// synchronised pins
	logic eci_sync;
	logic ext_sync;

	cawd_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.clk(clk),
		.resetn(resetn),
		.async_in({eci_pin, ext_clk_pin}),
		.sync_out({eci_sync, ext_sync})
	);

	// address decode
	wire sel_ctl = sfr_addr == ADDR_CTL_STATUS;
	wire sel_mode = sfr_addr == ADDR_MODE;
	wire sel_low = sfr_addr == ADDR_CNT_LOW;
	wire sel_high = sfr_addr == ADDR_CNT_HIGH;
	wire sel_off = sfr_addr == ADDR_WD_OFFSET;
	wire sel_upd = sfr_addr == ADDR_WD_UPDATE;

	wire wd_active = wd_enable_q | wd_lock_q;

	// control register image and the value a byte or bit write leaves in it
	wire [7:0] ctl_image = {ovf_flag_q, run_bit_q, 1'b0, event_flag_q};
	wire [7:0] bit_mask = 8'h01 << sfr_bit_idx;
	wire [7:0] bit_merged = sfr_bit_val ? (ctl_image | bit_mask) : (ctl_image & ~bit_mask);
	wire ctl_byte_wr = sfr_wr & sel_ctl;
	wire ctl_bit_wr = sfr_bit_wr & sel_ctl;
	wire ctl_wr = ctl_byte_wr | ctl_bit_wr;
	wire [7:0] ctl_wval = ctl_byte_wr ? sfr_wdata : bit_merged;

	// a byte write with bit 4 set or a bit write of 1 to the module 4 flag counts, so bit writes to other bits
	// with the flag already set cannot trip the watchdog by accident
	wire mod4_write_one = (ctl_byte_wr & sfr_wdata[CTL_MOD4_BIT])
		| (ctl_bit_wr & sfr_bit_val & (sfr_bit_idx == 3'(CTL_MOD4_BIT)));
	wire force_reset = wd_active & mod4_write_one;

	wire mode_wr = sfr_wr & sel_mode;
	wire low_wr = sfr_wr & sel_low & ~wd_active;
	wire high_wr = sfr_wr & sel_high & ~wd_active;
	wire off_wr = sfr_wr & sel_off;
	wire upd_wr = sfr_wr & sel_upd;

	// counter runs when software asks, or always while the watchdog is on
	wire counting = run_bit_q | wd_active;
	wire idle_hold = idle_suspend_q & cpu_idle;

	// timebase ticks
	wire [3:0] presc_last = (timebase_q == CAWD_TB_DIV4) ? DIV4_LAST : DIV12_LAST;
	wire presc_wrap = presc_q >= presc_last;
	wire eci_fall = eci_prev_q & ~eci_sync;
	wire ext_rise = ext_sync & ~ext_prev_q;
	wire ext_tick = ext_rise & (ext_div_q == EXTDIV_LAST);

	logic tb_tick;
	always_comb begin
		tb_tick = 1'b0;
		unique case (timebase_q)
			CAWD_TB_DIV12: tb_tick = presc_wrap;
			CAWD_TB_DIV4: tb_tick = presc_wrap;
			CAWD_TB_TIMER0: tb_tick = timer0_ovf;
			CAWD_TB_ECI: tb_tick = eci_fall;
			CAWD_TB_SYSTEM_CLOCK: tb_tick = 1'b1;
			CAWD_TB_EXTDIV8: tb_tick = ext_tick;
			default: tb_tick = 1'b0;
		endcase
	end

	wire cnt_tick = tb_tick & counting & ~idle_hold;
	wire low_ovf = cnt_tick & (cnt_low_q == BYTE_MAX);
	wire cnt_wrap = low_ovf & (cnt_high_q == BYTE_MAX);
	wire [7:0] cnt_low_d = low_wr ? sfr_wdata : (cnt_tick ? cnt_low_q + 8'h01 : cnt_low_q);
	wire [7:0] cnt_high_d = high_wr ? sfr_wdata : (low_ovf ? cnt_high_q + 8'h01 : cnt_high_q);

	// watchdog expiry on low-byte overflow while high bytes match
	wire wd_expire = wd_active & low_ovf & (cnt_high_q == wd_update_q);

	// flag updates: hardware set wins over a software clear in the same cycle
	wire ovf_flag_d = cnt_wrap | (ctl_wr ? ctl_wval[CTL_OVF_BIT] : ovf_flag_q);
	wire [NUM_MODULES-1:0] event_flag_d =
		module_event | (ctl_wr ? ctl_wval[NUM_MODULES-1:0] : event_flag_q);

	// mode register: enable and lock
	wire lock_d = wd_lock_q | (mode_wr & sfr_wdata[MODE_LOCK_BIT]);
	wire enable_d = wd_lock_q ? 1'b1 : (mode_wr ? sfr_wdata[MODE_WDTEN_BIT] : wd_enable_q);
	wire cfg_open = mode_wr & ~wd_active;

	wire irq_d = (ovf_flag_q & ovf_irq_en_q) | |(event_flag_q & module_irq_en);

	// read mux
	wire [7:0] mode_image = {idle_suspend_q, wd_enable_q, wd_lock_q, 1'b0, timebase_q, ovf_irq_en_q};
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (sel_ctl) begin
			rd_mux = ctl_image;
		end else if (sel_mode) begin
			rd_mux = mode_image;
		end else if (sel_low) begin
			rd_mux = cnt_low_q;
		end else if (sel_high) begin
			rd_mux = cnt_high_q;
		end else if (sel_off) begin
			rd_mux = wd_offset_q;
		end else if (sel_upd) begin
			rd_mux = wd_update_q;
		end
	end

	// hardware-set flags
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ovf_flag_q <= CTL_RESET[CTL_OVF_BIT];
			event_flag_q <= CTL_RESET[NUM_MODULES-1:0];
		end else begin
			ovf_flag_q <= ovf_flag_d;
			event_flag_q <= event_flag_d;
		end
	end

	// run bit keeps what software wrote; the watchdog forces counting without touching it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			run_bit_q <= CTL_RESET[CTL_RUN_BIT];
		end else if (ctl_wr) begin
			run_bit_q <= ctl_wval[CTL_RUN_BIT];
		end
	end

	// watchdog enable and lock
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wd_enable_q <= WDTEN_RESET;
			wd_lock_q <= 1'b0;
		end else begin
			wd_enable_q <= enable_d;
			wd_lock_q <= lock_d;
		end
	end

	// configuration bits, frozen while the watchdog runs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			idle_suspend_q <= 1'b0;
			timebase_q <= TB_RESET;
			ovf_irq_en_q <= 1'b0;
		end else if (cfg_open) begin
			idle_suspend_q <= sfr_wdata[MODE_IDLE_BIT];
			timebase_q <= sfr_wdata[MODE_TB_MSB:MODE_TB_LSB];
			ovf_irq_en_q <= sfr_wdata[MODE_OVFIE_BIT];
		end
	end

	// counter bytes; software writes are refused while the watchdog is on
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_low_q <= CNT_BYTE_RESET;
		end else begin
			cnt_low_q <= cnt_low_d;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_high_q <= CNT_BYTE_RESET;
		end else begin
			cnt_high_q <= cnt_high_d;
		end
	end

	// module 4 offset and update bytes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wd_offset_q <= WD_OFFSET_RESET;
			wd_update_q <= WD_UPDATE_RESET;
		end else begin
			if (off_wr) begin
				wd_offset_q <= sfr_wdata;
			end
			if (upd_wr) begin
				wd_update_q <= cnt_high_q + wd_offset_q;
			end
		end
	end

	// system clock prescaler; free running so a divide ratio change takes effect at once
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			presc_q <= 4'h0;
		end else if (presc_wrap) begin
			presc_q <= 4'h0;
		end else begin
			presc_q <= presc_q + 4'h1;
		end
	end

	// pin edge detection and external clock divider
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			eci_prev_q <= 1'b0;
			ext_prev_q <= 1'b0;
			ext_div_q <= 3'h0;
		end else begin
			eci_prev_q <= eci_sync;
			ext_prev_q <= ext_sync;
			if (ext_rise) begin
				ext_div_q <= ext_div_q + 3'h1;
			end
		end
	end

	// registered outputs; read data holds until the next read
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 8'h00;
		end else if (sfr_rd) begin
			rdata_q <= rd_mux;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// one cycle is enough: the system reset it triggers also clears this block
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wd_req_q <= 1'b0;
		end else begin
			wd_req_q <= wd_expire | force_reset;
		end
	end

	assign sfr_rdata = rdata_q;
	assign counter_irq = irq_q;
	assign wd_reset_req = wd_req_q;

endmodule

/* verification/cawd_chk.sv */
`timescale 1ns/100ps
module cawd_chk
	import cawd_pkg::*;
(
	input wire logic clk, // clock
	input wire logic resetn, // reset
	input wire logic [7:0] sfr_addr, // address
	input wire logic sfr_wr, // byte write
	input wire logic [7:0] sfr_wdata, // write data
	input wire logic sfr_bit_wr, // bit write
	input wire logic [2:0] sfr_bit_idx, // bit index
	input wire logic sfr_bit_val, // bit value
	input wire logic sfr_rd, // read
	input wire logic [7:0] sfr_rdata, // read data
	input wire logic [NUM_MODULES-1:0] module_event, // events
	input wire logic [NUM_MODULES-1:0] module_irq_en, // enables
	input wire logic counter_irq, // irq
	input wire logic wd_reset_req // reset request
);
	// shadow of enable and lock, which the design keeps internal
	logic en_q;
	logic lk_q;
	wire mode_wr = sfr_wr && sfr_addr == ADDR_MODE;
	wire bit4_wr = sfr_bit_wr && sfr_bit_idx == 3'h4 && sfr_bit_val;
	wire force_wr = en_q && sfr_addr == ADDR_CTL_STATUS && (sfr_wr ? sfr_wdata[4] : bit4_wr);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			en_q <= 1'b1;
			lk_q <= 1'b0;
		end else if (mode_wr) begin
			en_q <= lk_q | sfr_wdata[5] | sfr_wdata[6];
			lk_q <= lk_q | sfr_wdata[5];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wd_pulse_a: assert property (wd_reset_req |=> !wd_reset_req)
		else $error("watchdog reset request longer than one cycle");
	force_rst_a: assert property (force_wr |=> wd_reset_req)
		else $error("forced watchdog reset missing");
	rst_needs_en_a: assert property (wd_reset_req |-> $past(en_q))
		else $error("watchdog reset while disabled");
	ctl_bit5_a: assert property (sfr_rd && sfr_addr == ADDR_CTL_STATUS |=> !sfr_rdata[CTL_UNUSED_BIT])
		else $error("unused control bit reads one");
	unmapped_a: assert property (sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	rd_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data changed without a read");
	irq_set_a: assert property (|(module_event & module_irq_en) ##1
		(!sfr_wr && !sfr_bit_wr && $stable(module_irq_en)) |=> counter_irq)
		else $error("module event did not raise irq");
	irq_fall_a: assert property ($fell(counter_irq) |-> $past(sfr_wr || sfr_bit_wr, 2) ||
		$past(module_irq_en, 2) != $past(module_irq_en))
		else $error("irq dropped without software action");
	force_c: cover property (force_wr ##1 wd_reset_req);
	irq_c: cover property ($rose(counter_irq));
	timeout_c: cover property (wd_reset_req && !$past(force_wr));
endmodule
bind cawd_top cawd_chk chk (.clk, .resetn, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_bit_wr, .sfr_bit_idx,
	.sfr_bit_val, .sfr_rd, .sfr_rdata, .module_event, .module_irq_en, .counter_irq, .wd_reset_req);

/* verification/counter_array_watchdog_control_tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module counter_array_watchdog_control_tb_top
	import cawd_pkg::*;
;
	logic clk = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0, sfr_rd = 1'b0;
	logic cpu_idle = 1'b0, timer0_ovf = 1'b0, eci_pin = 1'b0, ext_clk_pin = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d, h;
	logic [2:0] sfr_bit_idx = 3'h0;
	logic [NUM_MODULES-1:0] module_event = '0, module_irq_en = '0;
	logic counter_irq, wd_reset_req;
	int bad_count = 0, n_compared = 0, cyc = 0, n;
	cawd_top uut (.clk, .resetn, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_bit_wr, .sfr_bit_idx, .sfr_bit_val,
		.sfr_rd, .sfr_rdata, .cpu_idle, .timer0_ovf, .eci_pin, .ext_clk_pin, .module_event, .module_irq_en,
		.counter_irq, .wd_reset_req);
	always #5 clk = ~clk;
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		sfr_addr <= a;
		sfr_wdata <= v;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic bwr(input logic [2:0] i, input logic v);
		sfr_addr <= ADDR_CTL_STATUS;
		sfr_bit_idx <= i;
		sfr_bit_val <= v;
		sfr_bit_wr <= 1'b1;
		@(posedge clk);
		sfr_bit_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		@(posedge clk);
		d = sfr_rdata;
	endtask
	// sampled on the falling edge so the one-cycle pulse is seen settled
	task automatic wait_rst(input int lim);
		n = 0;
		while (wd_reset_req !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
	endtask
	// the bench plays the system reset logic that answers the request
	task automatic sys_reset();
		@(posedge clk);
		resetn <= 1'b0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
	endtask
	task automatic t_defaults();
		logic [7:0] a [6] = '{ADDR_CTL_STATUS, ADDR_MODE, ADDR_CNT_LOW, ADDR_WD_OFFSET, ADDR_WD_UPDATE, 8'h00};
		logic [7:0] e [6] = '{CTL_RESET, 8'h40, CNT_BYTE_RESET, WD_OFFSET_RESET, WD_UPDATE_RESET, 8'h00};
		for (int i = 0; i < 6; i++) begin
			rd(a[i]);
			`CHK("reset_value", e[i], d)
		end
	endtask
	task automatic t_disable();
		wr(ADDR_MODE, 8'h00);
		rd(ADDR_MODE);
		`CHK("mode_off", 8'h00, d)
		bwr(3'h4, 1'b1);
		wait_rst(3200);
		`CHK("no_reset_off", 1'b1, n == 3200)
		rd(ADDR_CTL_STATUS);
		`CHK("flag4_sw", 8'h10, d)
		wr(ADDR_CTL_STATUS, 8'h20);
		rd(ADDR_CTL_STATUS);
		`CHK("ctl_bit5", 8'h00, d)
	endtask
	task automatic t_cfg(input logic [2:0] tb, input logic [7:0] off, input int lo, input int hi);
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_MODE, {4'h0, tb, 1'b0});
		wr(ADDR_WD_OFFSET, off);
		wr(ADDR_MODE, {4'h4, tb, 1'b0});
		wr(ADDR_MODE, 8'hcb);
		rd(ADDR_MODE);
		`CHK("mode_frozen", {4'h4, tb, 1'b0}, d)
		rd(ADDR_CNT_HIGH);
		h = d + off;
		wr(ADDR_WD_UPDATE, 8'h00);
		rd(ADDR_WD_UPDATE);
		`CHK("update_byte", 1'b1, d === h || d === h + 8'h01)
		wait_rst(hi);
		`CHK("timeout_window", 1'b1, n >= lo && n < hi)
		sys_reset();
	endtask
	task automatic t_lock();
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_MODE, 8'h20);
		wr(ADDR_MODE, 8'h00);
		rd(ADDR_MODE);
		`CHK("locked", 8'h60, d)
		bwr(3'h4, 1'b1);
		wait_rst(4);
		`CHK("forced_reset", 1'b1, n < 4)
		sys_reset();
		wr(ADDR_MODE, 8'h00);
		rd(ADDR_MODE);
		`CHK("unlocked", 8'h00, d)
	endtask
	task automatic t_flags();
		wr(ADDR_MODE, 8'h09);
		bwr(3'h6, 1'b1);
		wr(ADDR_CNT_LOW, 8'hf0);
		wr(ADDR_CNT_HIGH, 8'hff);
		repeat (30) @(posedge clk);
		rd(ADDR_CTL_STATUS);
		`CHK("overflow", 8'hc0, d)
		`CHK("ovf_irq", 1'b1, counter_irq)
		bwr(3'h7, 1'b0);
		repeat (3) @(posedge clk);
		rd(ADDR_CTL_STATUS);
		`CHK("ovf_clear", 8'h40, d)
		`CHK("ovf_irq_off", 1'b0, counter_irq)
		bwr(3'h6, 1'b0);
		rd(ADDR_CNT_LOW);
		h = d;
		rd(ADDR_CNT_LOW);
		`CHK("stopped", h, d)
		for (int i = 0; i < NUM_MODULES; i++) begin
			module_irq_en <= NUM_MODULES'(1 << i);
			module_event <= NUM_MODULES'(1 << i);
			@(posedge clk);
			module_event <= '0;
			repeat (3) @(posedge clk);
			`CHK("event_irq", 1'b1, counter_irq)
			rd(ADDR_CTL_STATUS);
			`CHK("event_flag", 8'(1 << i), d)
			bwr(3'(i), 1'b0);
			repeat (3) @(posedge clk);
			`CHK("event_irq_off", 1'b0, counter_irq)
		end
	endtask
	task automatic t_timeout();
		sys_reset();
		wait_rst(3200);
		`CHK("default_timeout", 1'b1, n >= 3072 && n <= 3074)
	endtask
	// watchdog off, undivided clock: reads two cycles apart differ by two ticks when counting
	task automatic t_idle();
		wr(ADDR_MODE, 8'h88);
		bwr(3'h6, 1'b1);
		cpu_idle <= 1'b1;
		rd(ADDR_CNT_LOW);
		h = d;
		rd(ADDR_CNT_LOW);
		`CHK("idle_halt", h, d)
		wr(ADDR_MODE, 8'h08);
		rd(ADDR_CNT_LOW);
		h = d;
		rd(ADDR_CNT_LOW);
		`CHK("idle_runs", h + 8'h02, d)
		cpu_idle <= 1'b0;
	endtask
	task automatic t_sources();
		wr(ADDR_MODE, 8'h04);
		bwr(3'h6, 1'b1);
		rd(ADDR_CNT_LOW);
		h = d;
		repeat (3) begin
			timer0_ovf <= 1'b1;
			@(posedge clk);
			timer0_ovf <= 1'b0;
			@(posedge clk);
		end
		rd(ADDR_CNT_LOW);
		`CHK("timer0_ticks", h + 8'h03, d)
		wr(ADDR_MODE, 8'h06);
		rd(ADDR_CNT_LOW);
		h = d;
		repeat (3) begin
			eci_pin <= 1'b1;
			repeat (4) @(posedge clk);
			eci_pin <= 1'b0;
			repeat (4) @(posedge clk);
		end
		rd(ADDR_CNT_LOW);
		`CHK("count_pin_falls", h + 8'h03, d)
		wr(ADDR_MODE, 8'h0a);
		rd(ADDR_CNT_LOW);
		h = d;
		repeat (16) begin
			ext_clk_pin <= 1'b1;
			repeat (3) @(posedge clk);
			ext_clk_pin <= 1'b0;
			repeat (3) @(posedge clk);
		end
		rd(ADDR_CNT_LOW);
		`CHK("ext_clk_div8", h + 8'h02, d)
		bwr(3'h6, 1'b0);
	endtask
	initial begin
		t_timeout();
		sys_reset();
		t_defaults();
		t_disable();
		t_cfg(3'h0, 8'h01, 3000, 6200);
		t_cfg(3'h1, 8'h01, 1000, 2100);
		t_cfg(3'h4, 8'h00, 0, 300);
		t_lock();
		t_flags();
		t_idle();
		t_sources();
		tally_and_finish();
	end
endmodule
